// ### hdl/mmd_decoder.v
// mmd_decoder.v: memory map decoder, dual-port ram host, vector address former
// assumes: cpu core issues one request per cycle; subsystem buses answer elsewhere
// Operation
// - 2 Kbyte dual-port ram decoded at 00F600 to 00FDFF.
// - register bank holds 16 words; first eight also as low/high bytes.
// - top 256 bytes of the ram accept single-bit accesses.
// - bit access works anywhere in the ram through the register port.
// - two 512 byte function register areas at 00FE00 and 00F000.
// - undefined nonvolatile register reads return trap code 1E9B.
// - vector segment comes from a segment register, offset from trap number.
// - vector offset is trap number times the spacing field's byte distance.
// - spacing resets to 4 bytes: trap 10H at 0040, 3FH at 00FC.
// - ram has two ports of its own; program, data sram and peripherals share one bus, each with its own strobe, one request at a time.
`timescale 1ns/100ps
`include "mmd_consts.vh"

module mmd_decoder (
  input wire clk_sys,
  input wire rst_n,
  // cpu data request
  input wire cpu_req,
  input wire cpu_wr,
  input wire [23:0] cpu_addr,
  input wire [1:0] cpu_be,
  input wire cpu_bit_op,
  input wire [3:0] cpu_bit_pos,
  input wire cpu_bit_val,
  input wire [15:0] cpu_wdata,
  output reg [15:0] cpu_rdata,
  output reg cpu_rvalid,
  output reg cpu_access_trap,
  output reg [`MMD_SEL_W-1:0] cpu_region,
  // general purpose register port
  input wire gpr_req,
  input wire gpr_wr,
  input wire gpr_byte,
  input wire [3:0] gpr_num,
  input wire gpr_bit_op,
  input wire [3:0] gpr_bit_pos,
  input wire gpr_bit_val,
  input wire [15:0] gpr_wdata,
  input wire [15:0] context_ptr,
  output reg [15:0] gpr_rdata,
  output reg gpr_rvalid,
  // separate subsystem buses
  output wire sfr_req,
  output wire efr_req,
  output wire xfr_req,
  output wire data_sram_req,
  output wire prog_req,
  output wire nvreg_req,
  output wire sub_wr,
  output wire [23:0] sub_addr,
  output wire [1:0] sub_be,
  output wire [15:0] sub_wdata,
  input wire [15:0] sfr_rdata,
  input wire [15:0] efr_rdata,
  input wire [15:0] xfr_rdata,
  input wire [15:0] data_sram_rdata,
  input wire [15:0] prog_rdata,
  input wire [15:0] nvreg_rdata,
  input wire nvreg_defined,
  // vector formation
  input wire vec_seg_wr,
  input wire [7:0] vec_seg_wdata,
  input wire vec_sc_wr,
  input wire [1:0] vec_sc_wdata,
  input wire [6:0] trap_num,
  output reg [23:0] vec_addr,
  output wire [7:0] vector_segment_register,
  output wire [1:0] vector_spacing_field
);

  // ----------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------
  // one-hot select; reserved holes fall into the trap select so exactly one bit is set
  function [`MMD_SEL_W-1:0] region_of;
    input [23:0] a;
    begin
      region_of = {`MMD_SEL_W{1'b0}};
      if (a >= `MMD_NVREG_START) begin
        region_of[`MMD_SEL_NVREG] = 1'b1;
      end else if (a >= `MMD_TRAP_START) begin
        region_of[`MMD_SEL_TRAP] = 1'b1;
      end else if (a >= `MMD_PROGRAM_SRAM_START && a <= `MMD_PROGRAM_SRAM_END) begin
        region_of[`MMD_SEL_PROG] = 1'b1;
      end else if (a >= `MMD_PFLASH_START && a <= `MMD_PFLASH_END) begin
        region_of[`MMD_SEL_PROG] = 1'b1;
      end else if (a >= `MMD_PERX_START && a <= `MMD_PERX_END) begin
        region_of[`MMD_SEL_XFR] = 1'b1;
      end else if (a >= `MMD_SFR_START && a <= `MMD_SFR_END) begin
        region_of[`MMD_SEL_SFR] = 1'b1;
      end else if (a >= `MMD_DPR_START && a <= `MMD_DPR_END) begin
        region_of[`MMD_SEL_DPR] = 1'b1;
      end else if (a >= `MMD_EFR_START && a <= `MMD_EFR_END) begin
        region_of[`MMD_SEL_EFR] = 1'b1;
      end else if (a >= `MMD_XFR_START && a <= `MMD_XFR_END) begin
        region_of[`MMD_SEL_XFR] = 1'b1;
      end else if (a >= `MMD_DATA_SRAM_START && a <= `MMD_DATA_SRAM_END) begin
        region_of[`MMD_SEL_DATA_SRAM] = 1'b1;
      end else begin
        region_of[`MMD_SEL_TRAP] = 1'b1; // reserved holes
      end
    end
  endfunction

  // bit-addressable window check for cpu bit ops
  function in_bit_area;
    input [23:0] a;
    begin
      in_bit_area = (a >= `MMD_BITADDR_BASE) && (a <= `MMD_DPR_END);
    end
  endfunction

  wire [`MMD_SEL_W-1:0] sel = region_of(cpu_addr);
  wire cpu_dpr = cpu_req && sel[`MMD_SEL_DPR];
  wire bit_bad = cpu_bit_op && !(sel[`MMD_SEL_DPR] && in_bit_area(cpu_addr));
  wire [23:0] cpu_off = cpu_addr - `MMD_DPR_START;
  wire [`MMD_DPR_AW-1:0] cpu_widx = cpu_off[`MMD_DPR_AW:1];

  // ----------------------------------------------------------------
  // separate buses: each subsystem sees only its own strobe
  // ----------------------------------------------------------------
  assign sfr_req = cpu_req && !cpu_bit_op && sel[`MMD_SEL_SFR];
  assign efr_req = cpu_req && !cpu_bit_op && sel[`MMD_SEL_EFR];
  assign xfr_req = cpu_req && !cpu_bit_op && sel[`MMD_SEL_XFR];
  assign data_sram_req = cpu_req && !cpu_bit_op && sel[`MMD_SEL_DATA_SRAM];
  assign prog_req = cpu_req && !cpu_bit_op && sel[`MMD_SEL_PROG];
  assign nvreg_req = cpu_req && !cpu_bit_op && sel[`MMD_SEL_NVREG];
  assign sub_wr = cpu_wr;
  assign sub_addr = cpu_addr;
  assign sub_be = cpu_be;
  assign sub_wdata = cpu_wdata;

  // ----------------------------------------------------------------
  // register bank address: context pointer plus register number
  // ----------------------------------------------------------------
  // byte registers 0..15 map to word 0..7, odd numbers are the high half
  wire [3:0] gpr_word = gpr_byte ? {1'b0, gpr_num[3:1]} : gpr_num;
  wire [15:0] gpr_baddr = context_ptr + {11'h000, gpr_word, 1'b0};
  wire [23:0] gpr_off = {8'h00, gpr_baddr} - `MMD_DPR_START;
  wire [`MMD_DPR_AW-1:0] gpr_widx = gpr_off[`MMD_DPR_AW:1];

  // ----------------------------------------------------------------
  // bit writes run read-modify-write over two cycles on each ram port
  // ----------------------------------------------------------------
  reg cpu_rmw_reg, cpu_rmw_val_reg, gpr_rmw_reg, gpr_rmw_val_reg;
  reg [`MMD_DPR_AW-1:0] cpu_rmw_idx_reg, gpr_rmw_idx_reg;
  reg [3:0] cpu_rmw_pos_reg, gpr_rmw_pos_reg;
  wire [15:0] a_rdata, b_rdata;

  // patch a single bit into a word
  function [15:0] set_bit;
    input [15:0] w;
    input [3:0] pos;
    input v;
    begin
      set_bit = w;
      set_bit[pos] = v;
    end
  endfunction

  wire cpu_bit_go = cpu_dpr && cpu_bit_op && cpu_wr && !bit_bad && !cpu_rmw_reg;
  wire gpr_bit_go = gpr_req && gpr_bit_op && gpr_wr && !gpr_rmw_reg;

  reg a_en, b_en;
  reg [1:0] a_we, b_we;
  reg [`MMD_DPR_AW-1:0] a_addr, b_addr;
  reg [15:0] a_wdata, b_wdata;

  // port a drive: a pending bit write-back takes the port for its cycle
  always @* begin
    a_en = 1'b0;
    a_we = 2'b00;
    a_addr = cpu_widx;
    a_wdata = cpu_wdata;
    if (cpu_rmw_reg) begin
      a_en = 1'b1;
      a_we = 2'b11;
      a_addr = cpu_rmw_idx_reg;
      a_wdata = set_bit(a_rdata, cpu_rmw_pos_reg, cpu_rmw_val_reg);
    end else if (cpu_dpr && !bit_bad) begin
      a_en = 1'b1;
      a_we = (cpu_wr && !cpu_bit_op) ? cpu_be : 2'b00;
    end
  end

  // port b drive: register bank, byte halves steered to their lane
  always @* begin
    b_en = 1'b0;
    b_we = 2'b00;
    b_addr = gpr_widx;
    b_wdata = gpr_byte ? {gpr_wdata[7:0], gpr_wdata[7:0]} : gpr_wdata;
    if (gpr_rmw_reg) begin
      b_en = 1'b1;
      b_we = 2'b11;
      b_addr = gpr_rmw_idx_reg;
      b_wdata = set_bit(b_rdata, gpr_rmw_pos_reg, gpr_rmw_val_reg);
    end else if (gpr_req) begin
      b_en = 1'b1;
      if (gpr_wr && !gpr_bit_op) begin
        b_we = gpr_byte ? (gpr_num[0] ? 2'b10 : 2'b01) : 2'b11;
      end
    end
  end

  mmd_dual_port_ram i_mmd_dual_port_ram (
    .clk_sys(clk_sys),
    .a_en(a_en),
    .a_we(a_we),
    .a_addr(a_addr),
    .a_wdata(a_wdata),
    .a_rdata(a_rdata),
    .b_en(b_en),
    .b_we(b_we),
    .b_addr(b_addr),
    .b_wdata(b_wdata),
    .b_rdata(b_rdata)
  );

  // ----------------------------------------------------------------
  // answer side: region and trap one cycle after the request, read data and valid two cycles after
  // ----------------------------------------------------------------
  reg [`MMD_SEL_W-1:0] sel_d_reg;
  reg rd_d_reg, gpr_rd_reg, gpr_hi_reg, gpr_byte_reg, gpr_bitrd_reg, cpu_bitrd_reg;
  reg [3:0] gpr_pos_reg, cpu_pos_reg;
  reg [15:0] cpu_rdata_next;

  // read mux; undefined nonvolatile register locations answer with the trap code
  always @* begin
    cpu_rdata_next = 16'h0000;
    if (sel_d_reg[`MMD_SEL_DPR]) begin
      cpu_rdata_next = cpu_bitrd_reg ? {15'h0000, a_rdata[cpu_pos_reg]} : a_rdata;
    end else if (sel_d_reg[`MMD_SEL_SFR]) begin
      cpu_rdata_next = sfr_rdata;
    end else if (sel_d_reg[`MMD_SEL_EFR]) begin
      cpu_rdata_next = efr_rdata;
    end else if (sel_d_reg[`MMD_SEL_XFR]) begin
      cpu_rdata_next = xfr_rdata;
    end else if (sel_d_reg[`MMD_SEL_DATA_SRAM]) begin
      cpu_rdata_next = data_sram_rdata;
    end else if (sel_d_reg[`MMD_SEL_PROG]) begin
      cpu_rdata_next = prog_rdata;
    end else if (sel_d_reg[`MMD_SEL_NVREG]) begin
      cpu_rdata_next = nvreg_defined ? nvreg_rdata : `MMD_TRAP_CODE;
    end
  end

  // ----------------------------------------------------------------
  // sequential state
  // ----------------------------------------------------------------
  reg [7:0] vec_seg_reg;
  reg [1:0] vec_sc_reg;
  // nvreg_defined comes from the same clock's register bank, no sync needed
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rmw_reg <= 1'b0;
      cpu_rmw_idx_reg <= {`MMD_DPR_AW{1'b0}};
      cpu_rmw_pos_reg <= 4'h0;
      cpu_rmw_val_reg <= 1'b0;
      gpr_rmw_reg <= 1'b0;
      gpr_rmw_idx_reg <= {`MMD_DPR_AW{1'b0}};
      gpr_rmw_pos_reg <= 4'h0;
      gpr_rmw_val_reg <= 1'b0;
      sel_d_reg <= {`MMD_SEL_W{1'b0}};
      rd_d_reg <= 1'b0;
      gpr_rd_reg <= 1'b0;
      gpr_hi_reg <= 1'b0;
      gpr_byte_reg <= 1'b0;
      gpr_bitrd_reg <= 1'b0;
      gpr_pos_reg <= 4'h0;
      cpu_bitrd_reg <= 1'b0;
      cpu_pos_reg <= 4'h0;
      cpu_rdata <= 16'h0000;
      cpu_rvalid <= 1'b0;
      cpu_access_trap <= 1'b0;
      cpu_region <= {`MMD_SEL_W{1'b0}};
      gpr_rdata <= 16'h0000;
      gpr_rvalid <= 1'b0;
      vec_seg_reg <= `MMD_VEC_SEG_RESET;
      vec_sc_reg <= `MMD_VEC_SC_RESET;
      vec_addr <= 24'h000000;
    end else begin
      cpu_rmw_reg <= cpu_bit_go;
      cpu_rmw_idx_reg <= cpu_widx;
      cpu_rmw_pos_reg <= cpu_bit_pos;
      cpu_rmw_val_reg <= cpu_bit_val;
      gpr_rmw_reg <= gpr_bit_go;
      gpr_rmw_idx_reg <= gpr_widx;
      gpr_rmw_pos_reg <= gpr_bit_pos;
      gpr_rmw_val_reg <= gpr_bit_val;
      // reads only; bit ops outside the window or trapping regions return nothing
      rd_d_reg <= cpu_req && !cpu_wr && !bit_bad && !sel[`MMD_SEL_TRAP] && !cpu_rmw_reg;
      sel_d_reg <= (cpu_req && !cpu_rmw_reg) ? sel : {`MMD_SEL_W{1'b0}};
      cpu_bitrd_reg <= cpu_bit_op;
      cpu_pos_reg <= cpu_bit_pos;
      cpu_region <= cpu_req ? sel : {`MMD_SEL_W{1'b0}};
      cpu_access_trap <= cpu_req && (sel[`MMD_SEL_TRAP] || bit_bad);
      cpu_rvalid <= rd_d_reg;
      cpu_rdata <= rd_d_reg ? cpu_rdata_next : cpu_rdata;
      gpr_rd_reg <= gpr_req && !gpr_wr && !gpr_rmw_reg;
      gpr_hi_reg <= gpr_num[0];
      gpr_byte_reg <= gpr_byte;
      gpr_bitrd_reg <= gpr_bit_op;
      gpr_pos_reg <= gpr_bit_pos;
      gpr_rvalid <= gpr_rd_reg;
      if (gpr_rd_reg) begin
        if (gpr_bitrd_reg) begin
          gpr_rdata <= {15'h0000, b_rdata[gpr_pos_reg]};
        end else if (gpr_byte_reg) begin
          gpr_rdata <= {8'h00, gpr_hi_reg ? b_rdata[15:8] : b_rdata[7:0]};
        end else begin
          gpr_rdata <= b_rdata;
        end
      end
      if (vec_seg_wr) begin
        vec_seg_reg <= vec_seg_wdata;
      end
      if (vec_sc_wr) begin
        vec_sc_reg <= vec_sc_wdata;
      end
      // spacing code n gives 2 << n bytes; shift widened so code 3 does not wrap to 0
      vec_addr <= {vec_seg_reg, 16'h0000} + ({17'h00000, trap_num} << ({1'b0, vec_sc_reg} + 3'd1));
    end
  end

  assign vector_segment_register = vec_seg_reg;
  assign vector_spacing_field = vec_sc_reg;

endmodule

// ### hdl/mmd_consts.vh
// mmd_consts.vh: address map, codes and reset values for the memory map decoder
// assumes: included by the decoder and its ram; definitions only
`ifndef MMD_CONSTS_VH
`define MMD_CONSTS_VH

// ----------------------------------------------------------------
// region boundaries (24-bit byte addresses)
// ----------------------------------------------------------------
// holes between these ranges decode to the trap select
`define MMD_DATA_SRAM_START 24'h00C000
`define MMD_DATA_SRAM_END 24'h00CFFF
`define MMD_XFR_START 24'h00E000
`define MMD_XFR_END 24'h00EFFF
`define MMD_EFR_START 24'h00F000
`define MMD_EFR_END 24'h00F1FF
`define MMD_DPR_START 24'h00F600
`define MMD_DPR_END 24'h00FDFF
`define MMD_SFR_START 24'h00FE00
`define MMD_SFR_END 24'h00FFFF
`define MMD_PERX_START 24'h200000
`define MMD_PERX_END 24'h2007FF
`define MMD_PFLASH_START 24'hC00000
`define MMD_PFLASH_END 24'hC1FFFF
`define MMD_PROGRAM_SRAM_START 24'hE00000
`define MMD_PROGRAM_SRAM_END 24'hE007FF
`define MMD_TRAP_START 24'hF80000
`define MMD_TRAP_END 24'hFFFFFF
`define MMD_NVREG_START 24'hFFF000
`define MMD_NVREG_END 24'hFFFFFF

// ----------------------------------------------------------------
// region select codes (one-hot bit positions)
// ----------------------------------------------------------------
`define MMD_SEL_W 8
`define MMD_SEL_DPR 0
`define MMD_SEL_SFR 1
`define MMD_SEL_EFR 2
`define MMD_SEL_XFR 3
`define MMD_SEL_DATA_SRAM 4
`define MMD_SEL_PROG 5
`define MMD_SEL_NVREG 6
`define MMD_SEL_TRAP 7

// ----------------------------------------------------------------
// ram geometry and codes
// ----------------------------------------------------------------
`define MMD_DPR_AW 10
`define MMD_DPR_WORDS 1024
`define MMD_BITADDR_BASE 24'h00FD00
`define MMD_TRAP_CODE 16'h1E9B
`define MMD_VEC_SC_RESET 2'h1
`define MMD_VEC_SEG_RESET 8'h00

`endif

// ### hdl/mmd_dual_port_ram.v
// mmd_dual_port_ram.v: 2 Kbyte dual-port ram, 1024 words of 16 bits, byte writes
// assumes: one clock; port a is the cpu data port, port b the register bank port
`timescale 1ns/100ps
`include "mmd_consts.vh"

module mmd_dual_port_ram (
  input wire clk_sys,
  input wire a_en,
  input wire [1:0] a_we,
  input wire [`MMD_DPR_AW-1:0] a_addr,
  input wire [15:0] a_wdata,
  output reg [15:0] a_rdata,
  input wire b_en,
  input wire [1:0] b_we,
  input wire [`MMD_DPR_AW-1:0] b_addr,
  input wire [15:0] b_wdata,
  output reg [15:0] b_rdata
);

  reg [15:0] mem [0:`MMD_DPR_WORDS-1];
  integer i;

  // ----------------------------------------------------------------
  // two independent ports; same-byte collisions favour port b
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (a_en) begin
      a_rdata <= mem[a_addr];
    end
    if (b_en) begin
      b_rdata <= mem[b_addr];
    end
    for (i = 0; i < 2; i = i + 1) begin
      if (a_en && a_we[i] && !(b_en && b_we[i] && (b_addr == a_addr))) begin
        mem[a_addr][i*8 +: 8] <= a_wdata[i*8 +: 8];
      end
      if (b_en && b_we[i]) begin
        mem[b_addr][i*8 +: 8] <= b_wdata[i*8 +: 8];
      end
    end
  end

endmodule

// ### tb/mmd_decoder_chk_sva.sv
// mmd_decoder_chk_sva.sv: timing and decode checks on the memory map decoder ports
// assumes: bound into mmd_decoder; one clock, asynchronous active low reset
`timescale 1ns/100ps
`include "mmd_consts.vh"

module mmd_decoder_chk (
  input wire clk_sys,
  input wire rst_n,
  input wire cpu_req,
  input wire cpu_wr,
  input wire [23:0] cpu_addr,
  input wire cpu_bit_op,
  input wire [15:0] cpu_rdata,
  input wire cpu_rvalid,
  input wire cpu_access_trap,
  input wire [`MMD_SEL_W-1:0] cpu_region,
  input wire gpr_req,
  input wire gpr_wr,
  input wire gpr_bit_op,
  input wire gpr_rvalid,
  input wire sfr_req,
  input wire efr_req,
  input wire xfr_req,
  input wire data_sram_req,
  input wire prog_req,
  input wire nvreg_req,
  input wire nvreg_defined,
  input wire vec_seg_wr,
  input wire [7:0] vec_seg_wdata,
  input wire vec_sc_wr,
  input wire [6:0] trap_num,
  input wire [23:0] vec_addr,
  input wire [7:0] vector_segment_register,
  input wire [1:0] vector_spacing_field
);
  reg rmw_reg;
  wire take = cpu_req && !rmw_reg && !cpu_bit_op;
  wire rd = take && !cpu_wr;
  wire [5:0] strb = {nvreg_req, prog_req, data_sram_req, xfr_req, efr_req, sfr_req};
  wire in_dpr = cpu_addr >= `MMD_DPR_START && cpu_addr <= `MMD_DPR_END;
  wire in_trap = cpu_addr >= `MMD_TRAP_START && cpu_addr < `MMD_NVREG_START;

  // ----------------------------------------------------------------
  // helper: the slot after any cpu bit access, read or write, is taken as the read-modify-write cycle
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rmw_reg <= 1'b0;
    end else begin
      rmw_reg <= cpu_req && cpu_bit_op && !rmw_reg;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_dpr_read;
    rd && in_dpr;
  endsequence
  sequence s_nv_undef;
    rd && cpu_addr >= `MMD_NVREG_START && !nvreg_defined;
  endsequence
  property p_dpr_read;
    s_dpr_read |-> ##1 cpu_region == 8'h01 ##1 cpu_rvalid;
  endproperty
  a_dpr_read: assert property (p_dpr_read) else $error("ram read not decoded or late");
  property p_sfr_sel;
    take && cpu_addr >= `MMD_SFR_START && cpu_addr <= `MMD_SFR_END |-> sfr_req && $onehot(strb);
  endproperty
  a_sfr_sel: assert property (p_sfr_sel) else $error("function area strobe wrong");
  property p_efr_sel;
    take && cpu_addr >= `MMD_EFR_START && cpu_addr <= `MMD_EFR_END |-> efr_req && $onehot(strb);
  endproperty
  a_efr_sel: assert property (p_efr_sel) else $error("extended area strobe wrong");
  property p_trap;
    take && in_trap |-> strb == 6'h00 ##1 cpu_access_trap && cpu_region == 8'h80;
  endproperty
  a_trap: assert property (p_trap) else $error("reserved access did not trap");
  property p_nv_code;
    s_nv_undef |-> ##2 cpu_rvalid && cpu_rdata == `MMD_TRAP_CODE;
  endproperty
  a_nv_code: assert property (p_nv_code) else $error("undefined location gave no trap code");
  property p_onehot;
    take |=> $onehot(cpu_region);
  endproperty
  a_onehot: assert property (p_onehot) else $error("region select not one-hot");
  property p_vec;
    !vec_seg_wr && !vec_sc_wr |=> vec_addr == ({vector_segment_register, 16'h0000}
      + ({17'h00000, $past(trap_num)} << ({1'b0, vector_spacing_field} + 3'd1)));
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_rst_vec;
    $rose(rst_n) |-> vector_spacing_field == `MMD_VEC_SC_RESET && vector_segment_register == 8'h00;
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("vector spacing reset wrong");
  property p_seg_wr;
    vec_seg_wr |=> vector_segment_register == $past(vec_seg_wdata);
  endproperty
  a_seg_wr: assert property (p_seg_wr) else $error("segment write lost");
  property p_gpr_read;
    gpr_req && !gpr_wr && !gpr_bit_op |-> ##2 gpr_rvalid;
  endproperty
  a_gpr_read: assert property (p_gpr_read) else $error("register read late");
endmodule

bind mmd_decoder mmd_decoder_chk i_mmd_decoder_chk (.*);

// ### tb/mmd_sub_model.sv
// mmd_sub_model.sv: behavioural subsystem buses answering the decoder's strobes
// assumes: one clock; strobe order sfr, efr, xfr, data_sram, prog, nvreg from bit 0
`timescale 1ns/100ps

module mmd_sub_model (
  input wire clk_sys,
  input wire [5:0] strb,
  input wire sub_wr,
  input wire [23:0] sub_addr,
  output wire [95:0] rdata_all,
  output wire nvreg_defined
);
  reg [15:0] rd_reg [0:5];
  integer i;

  // read data stands one cycle after the strobe; an idle bus toggles so stale data shows
  initial begin
    for (i = 0; i < 6; i = i + 1) begin
      rd_reg[i] = 16'h0F0F;
    end
  end
  always @(posedge clk_sys) begin
    for (i = 0; i < 6; i = i + 1) begin
      if (strb[i] && !sub_wr) begin
        rd_reg[i] <= sub_addr[15:0] ^ {8'hA5, i[7:0]};
      end else begin
        rd_reg[i] <= ~rd_reg[i];
      end
    end
  end
  assign rdata_all = {rd_reg[5], rd_reg[4], rd_reg[3], rd_reg[2], rd_reg[1], rd_reg[0]};
  // top 256 bytes of each 4 Kbyte page left undefined
  assign nvreg_defined = sub_addr[11:8] != 4'hF;
endmodule

// ### tb/test_memory_map_decoder.sv
// test_memory_map_decoder.sv: self-checking bench for the memory map decoder
// assumes: decoder and subsystem model in scope; checker attached by bind
`timescale 1ns/100ps
`include "mmd_consts.vh"

module test_memory_map_decoder;
  reg clk_sys, rst_n, cpu_req, cpu_wr, cpu_bit_op, cpu_bit_val, vec_seg_wr, vec_sc_wr;
  reg gpr_req, gpr_wr, gpr_byte, gpr_bit_op, gpr_bit_val;
  reg [23:0] cpu_addr;
  reg [1:0] cpu_be, vec_sc_wdata;
  reg [3:0] cpu_bit_pos, gpr_num, gpr_bit_pos;
  reg [15:0] cpu_wdata, gpr_wdata, context_ptr, q;
  reg [7:0] vec_seg_wdata, seen_reg;
  reg [6:0] trap_num;
  reg [5:0] seen_strb;
  reg seen_trap;
  reg [31:0] rows [0:33];
  wire [15:0] cpu_rdata, gpr_rdata, sub_wdata;
  wire [7:0] cpu_region, vseg;
  wire [1:0] vsc, sub_be;
  wire [23:0] sub_addr, vec_addr;
  wire [95:0] sub_rd;
  wire cpu_rvalid, cpu_access_trap, gpr_rvalid, sub_wr, nvreg_defined;
  wire sfr_req, efr_req, xfr_req, data_sram_req, prog_req, nvreg_req;
  wire [5:0] strb = {nvreg_req, prog_req, data_sram_req, xfr_req, efr_req, sfr_req};
  integer failures, tests_run, i, n;

  mmd_decoder i_mmd_decoder (.*, .sfr_rdata(sub_rd[15:0]), .efr_rdata(sub_rd[31:16]), .xfr_rdata(sub_rd[47:32]),
    .data_sram_rdata(sub_rd[63:48]), .prog_rdata(sub_rd[79:64]), .nvreg_rdata(sub_rd[95:80]),
    .vector_segment_register(vseg), .vector_spacing_field(vsc));
  mmd_sub_model i_mmd_sub_model (.clk_sys, .strb, .sub_wr, .sub_addr, .rdata_all(sub_rd), .nvreg_defined);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input string name, input [23:0] seen, input [23:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("Error %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // every access spends an idle slot afterwards, which also covers the bit write-back
  task cpu_acc(input [23:0] a, input w, input bop, input [3:0] bp, input [15:0] d, input [1:0] be);
    begin
      @(posedge clk_sys);
      cpu_req <= 1'b1;
      cpu_addr <= a;
      cpu_wr <= w;
      cpu_bit_op <= bop;
      cpu_bit_pos <= bp;
      cpu_wdata <= d;
      cpu_be <= be;
      #1 seen_strb = strb;
      @(posedge clk_sys);
      cpu_req <= 1'b0;
      #1 seen_reg = cpu_region;
      seen_trap = cpu_access_trap;
      @(posedge clk_sys);
      #1 q = cpu_rdata;
      if (!w && seen_reg !== 8'h80) chk("cpu read valid", cpu_rvalid, 1'b1);
    end
  endtask
  task gpr_acc(input w, input by, input [3:0] nm, input bop, input [3:0] bp, input [15:0] d);
    begin
      @(posedge clk_sys);
      gpr_req <= 1'b1;
      gpr_wr <= w;
      gpr_byte <= by;
      gpr_num <= nm;
      gpr_bit_op <= bop;
      gpr_bit_pos <= bp;
      gpr_wdata <= d;
      @(posedge clk_sys);
      gpr_req <= 1'b0;
      @(posedge clk_sys);
      #1 q = gpr_rdata;
      if (!w) chk("register read valid", gpr_rvalid, 1'b1);
    end
  endtask
  // subsystem answer as the model forms it; undefined register pages give the trap code
  function [15:0] exp_rd(input [23:0] a, input [5:0] s);
    integer k;
    begin
      exp_rd = a[15:0] ^ 16'hA500;
      for (k = 0; k < 6; k = k + 1) begin
        if (s[k]) exp_rd = a[15:0] ^ {8'hA5, k[7:0]};
      end
      if (s[5] && a[11:8] == 4'hF) exp_rd = `MMD_TRAP_CODE;
    end
  endfunction
  task conclude;
    begin
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, cpu_req, cpu_wr, cpu_bit_op, vec_seg_wr, vec_sc_wr, gpr_req, gpr_wr, gpr_byte, gpr_bit_op} = 10'h000;
    {cpu_addr, cpu_be, vec_sc_wdata, cpu_bit_pos, gpr_num, gpr_bit_pos, cpu_wdata, gpr_wdata} = 0;
    cpu_bit_val = 1'b1;
    gpr_bit_val = 1'b1;
    vec_seg_wdata = 8'h00;
    context_ptr = 16'hF800;
    trap_num = 7'h10;
    failures = 0;
    tests_run = 0;
    rows = '{32'h00FE0002, 32'h00FFFE02, 32'h00F00004, 32'h00F1FE04, 32'h00E00008, 32'h00EFFE08,
      32'h20000008, 32'h2007FE08, 32'h00C00010, 32'h00CFFE10, 32'hC0000020, 32'hC1FFFE20,
      32'hE0000020, 32'hE007FE20, 32'hFFF00040, 32'hFFFFFE40, 32'h00000080, 32'h007FFE80,
      32'h00800080, 32'h00BFFE80, 32'h00D00080, 32'h00DFFE80, 32'h00F20080, 32'h00F5FE80,
      32'h01000080, 32'h1FFFFE80, 32'h20080080, 32'hBFFFFE80, 32'hC2000080, 32'hDFFFFE80,
      32'hE0080080, 32'hF7FFFE80, 32'hF8000080, 32'hFFEFFE80};
    repeat (16) @(posedge clk_sys);
    #1 chk("spacing in reset", vsc, 2'h1);
    chk("read valid in reset", cpu_rvalid, 1'b0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk("vector trap 10", vec_addr, 24'h000040);
    @(posedge clk_sys);
    trap_num <= 7'h3F;
    repeat (2) @(posedge clk_sys);
    #1 chk("vector trap 3F", vec_addr, 24'h0000FC);
    for (n = 0; n < 4; n = n + 1) begin
      @(posedge clk_sys);
      vec_seg_wr <= 1'b1;
      vec_seg_wdata <= 8'h5A;
      vec_sc_wr <= 1'b1;
      vec_sc_wdata <= n[1:0];
      @(posedge clk_sys);
      vec_seg_wr <= 1'b0;
      vec_sc_wr <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 chk("vector address", vec_addr, 24'h5A0000 + (24'h3F << (n + 1)));
    end
    $display("test vectors done");
    for (i = 0; i < 34; i = i + 1) begin
      cpu_acc(rows[i][31:8], 1'b0, 1'b0, 4'h0, 16'h0000, 2'h3);
      chk("region", seen_reg, rows[i][7:0]);
      chk("access trap", seen_trap, rows[i][7]);
      chk("subsystem strobe", seen_strb, rows[i][6:1]);
      if (!rows[i][7]) chk("read data", q, exp_rd(rows[i][31:8], rows[i][6:1]));
    end
    $display("test address map done");
    cpu_acc(24'h00FFFE, 1'b1, 1'b0, 4'h0, 16'h0000, 2'h3);
    chk("zero write strobe", seen_strb, 6'h01);
    chk("write lanes", {sub_wr, sub_be, sub_wdata}, 19'h70000);
    cpu_acc(24'h00F600, 1'b1, 1'b0, 4'h0, 16'h1234, 2'h3);
    cpu_acc(24'h00FDFE, 1'b1, 1'b0, 4'h0, 16'hBEEF, 2'h3);
    cpu_acc(24'h00F600, 1'b1, 1'b0, 4'h0, 16'hAB00, 2'h2);
    cpu_acc(24'h00F600, 1'b0, 1'b0, 4'h0, 16'h0000, 2'h3);
    chk("ram region", seen_reg, 8'h01);
    chk("ram byte lane", q, 16'hAB34);
    cpu_acc(24'h00FDFE, 1'b1, 1'b1, 4'h4, 16'h0000, 2'h3);
    cpu_acc(24'h00FDFE, 1'b0, 1'b0, 4'h0, 16'h0000, 2'h3);
    chk("top bit set", q, 16'hBEFF);
    cpu_acc(24'h00FDFE, 1'b0, 1'b1, 4'h4, 16'h0000, 2'h3);
    chk("top bit read", q, 16'h0001);
    cpu_acc(24'h00F600, 1'b1, 1'b1, 4'h0, 16'h0000, 2'h3);
    chk("low bit trap", seen_trap, 1'b1);
    cpu_acc(24'h00F600, 1'b0, 1'b0, 4'h0, 16'h0000, 2'h3);
    chk("low bit no effect", q, 16'hAB34);
    $display("test ram done");
    gpr_acc(1'b1, 1'b0, 4'hF, 1'b0, 4'h0, 16'hC3C3);
    cpu_acc(24'h00F81E, 1'b0, 1'b0, 4'h0, 16'h0000, 2'h3);
    chk("register 15 in ram", q, 16'hC3C3);
    gpr_acc(1'b1, 1'b0, 4'h0, 1'b0, 4'h0, 16'h0011);
    gpr_acc(1'b1, 1'b1, 4'h1, 1'b0, 4'h0, 16'h00AB);
    gpr_acc(1'b0, 1'b0, 4'h0, 1'b0, 4'h0, 16'h0000);
    chk("high byte write", q, 16'hAB11);
    gpr_acc(1'b0, 1'b1, 4'h1, 1'b0, 4'h0, 16'h0000);
    chk("high byte read", q, 16'h00AB);
    gpr_acc(1'b1, 1'b0, 4'h2, 1'b0, 4'h0, 16'h0000);
    gpr_acc(1'b1, 1'b0, 4'h2, 1'b1, 4'h3, 16'h0000);
    cpu_acc(24'h00F804, 1'b0, 1'b0, 4'h0, 16'h0000, 2'h3);
    chk("register bit low ram", q, 16'h0008);
    gpr_acc(1'b0, 1'b0, 4'h2, 1'b1, 4'h3, 16'h0000);
    chk("register bit read", q, 16'h0001);
    $display("test registers done");
    conclude;
  end
endmodule
